// ---- logic/sc_defs.vh ----
// register map, field positions, reset values and timing counts
`ifndef SC_DEFS_VH
`define SC_DEFS_VH
`define A_SUPPLY 16'hFE03
`define A_PROTO 16'hFE10
`define A_CLKREG 16'hFE11
`define A_ETU 16'hFE12
`define A_RLEN 16'hFE13
`define A_INT 16'hFE14
`define A_IE 16'hFE15
`define A_CCTL 16'hFE16
`define A_TXCTL 16'hFE17
`define A_RXCTL 16'hFE18
`define A_TXDATA 16'hFE19
`define A_RXDATA 16'hFE1A
`define B_PRIM_SYNC 7
`define B_NINE 6
`define B_SEC_SYNC 5
`define B_LEN 7
`define B_RECEIVE_DATA_AVAILABLE 0
`define B_STOP 0
`define B_LVL 1
`define B_DLINE 7
`define B_TXDIR 6
`define B_IODATA 0
`define B_IODIR 1
`define B_IOSAMP 5
`define B_NINTH 7
`define B_RXEMPTY 0
`define B_VSEL1 7
`define B_VSEL0 6
`define B_FAULT 5
`define B_READY_START 4
`define B_VGOOD 3
`define B_PWROFF 0
`define ETU_DIV_RST 8'h08
`define SUPPLY_RST 8'h00
`define CLK_PERIOD_NS 10
`define SUPPLY_TIME_US 10
`define SUPPLY_CYC ((`SUPPLY_TIME_US * 1000) / `CLK_PERIOD_NS)
`define ST_IDLE 3'h0
`define ST_WAIT 3'h1
`define ST_ACTIVE 3'h2
`define ST_D_RST 3'h3
`define ST_D_CLK 3'h4
`define ST_D_IO 3'h5
`define ST_D_VCC 3'h6
`endif

// ---- logic/sync2.v ----
// two-flop synchroniser for a group of asynchronous levels
module sync2 #(
  parameter W = 1
) (
  // clock and reset
  input wire core_clk,
  input wire srst,
  // levels
  input wire [W-1:0] d,
  output wire [W-1:0] q
);
  reg [W-1:0] meta_ff;
  reg [W-1:0] hold_ff;
  always @(posedge core_clk) begin
    if (srst) begin
      meta_ff <= {W{1'b0}};
      hold_ff <= {W{1'b0}};
    end else begin
      meta_ff <= d;
      hold_ff <= meta_ff;
    end
  end
  assign q = hold_ff;
endmodule // sync2

// ---- logic/sc_sync_supply.v ----
// smart card synchronous-mode engine and card supply sequencer
//
// Decided for this implementation: strobed register access.
`include "sc_defs.vh"
module sc_sync_supply (
  // clock and reset
  input wire core_clk,
  input wire srst,
  // register port
  input wire [15:0] addr,
  input wire [7:0] wr_data,
  input wire wr_stb,
  input wire rd_stb,
  output reg [7:0] rd_data_ff,
  // card pins
  output reg card_clk_ff,
  input wire card_io_in,
  output reg card_io_out_ff,
  output reg card_io_oe_n_ff,
  output reg card_rst_n_ff,
  // supply and system status
  input wire card_event_in,
  input wire supply_good_in,
  input wire supply_fault_in,
  input wire bus_power_in,
  output reg [1:0] vcc_sel_out_ff,
  output reg chip_off_ff,
  output reg irq_ff
);
  wire [4:0] sync_q;
  wire s_io;
  wire s_event;
  wire s_good;
  wire s_fault;
  wire s_bus;
  sync2 #(.W(5)) u_sync (
    .core_clk(core_clk),
    .srst(srst),
    .d({card_io_in, card_event_in, supply_good_in, supply_fault_in,
        bus_power_in}),
    .q(sync_q)
  );
  assign {s_io, s_event, s_good, s_fault, s_bus} = sync_q;

  reg [7:0] proto_ff;
  reg clk_stop_ff, clk_lvl_ff;
  reg [7:0] etu_div_ff;
  reg [7:0] rlen_load_ff, rlen_cnt_ff;
  reg rlen_fresh_ff;
  reg len_flag_ff, receive_data_available_ff;
  reg [7:0] ie_ff;
  reg cctl_data_ff, cctl_dir_ff, io_samp_ff;
  reg dline_ff, txdir_ff, ninth_ff;
  reg [7:0] tx_mem [0:3];
  reg [1:0] tx_wp_ff, tx_rp_ff;
  reg [2:0] tx_cnt_ff;
  reg tx_rd_prev_ff;
  reg [8:0] rx_mem [0:3];
  reg [1:0] rx_wp_ff, rx_rp_ff;
  reg [2:0] rx_cnt_ff;
  reg [8:0] shift_ff;
  reg [3:0] bitp_ff;
  reg [1:0] vsel_ff, vcode_ff;
  reg fault_en_ff, ready_start_ff, pwroff_ff, lock_ff, good_d_ff;
  reg [2:0] state_ff;
  reg [15:0] tmr_ff;
  reg [7:0] hcnt_ff;
  reg stopped_ff;

  // card clock generator
  wire sync_run = proto_ff[`B_PRIM_SYNC] &
    (state_ff == `ST_ACTIVE || state_ff == `ST_D_RST);
  // half period from the full ETU period, never below one cycle
  wire [7:0] half = (etu_div_ff[7:1] == 7'h00) ? 8'h01 :
    {1'b0, etu_div_ff[7:1]};
  reg nxt_clk, nxt_stopped, restart_high;
  reg [7:0] nxt_hcnt;
  always @* begin
    nxt_clk = card_clk_ff;
    nxt_stopped = stopped_ff;
    nxt_hcnt = hcnt_ff + 8'h01;
    restart_high = 1'b0;
    if (!sync_run) begin
      nxt_clk = 1'b0;
      nxt_stopped = 1'b1;
      nxt_hcnt = 8'h00;
    end else if (stopped_ff) begin
      nxt_hcnt = 8'h00;
      if (!clk_stop_ff) begin
        nxt_stopped = 1'b0;
        if (card_clk_ff) begin
          nxt_clk = 1'b0;
          restart_high = 1'b1;
        end
      end
    end else if (hcnt_ff >= half - 8'h01) begin
      nxt_hcnt = 8'h00;
      // while running, toggles only at a half-period boundary; a drop of sync_run still forces the clock low at once
      if (clk_stop_ff && card_clk_ff == clk_lvl_ff)
        nxt_stopped = 1'b1;
      else
        nxt_clk = ~card_clk_ff;
    end
  end
  always @(posedge core_clk) begin
    if (srst) begin
      card_clk_ff <= 1'b0;
      stopped_ff <= 1'b1;
      hcnt_ff <= 8'h00;
    end else begin
      card_clk_ff <= nxt_clk;
      stopped_ff <= nxt_stopped;
      hcnt_ff <= nxt_hcnt;
    end
  end

  wire fall_ev = card_clk_ff & ~nxt_clk;
  wire rise_ev = ~card_clk_ff & nxt_clk;
  wire counting = (rlen_load_ff != 8'h00) && (rlen_cnt_ff < rlen_load_ff);
  wire count_fall = fall_ev & counting &
    ~(restart_high & rlen_fresh_ff);
  wire direct = (rlen_load_ff == 8'h00) ||
    (rlen_cnt_ff == rlen_load_ff && dline_ff);
  wire tx_bit = tx_mem[tx_rp_ff][bitp_ff[2:0]];
  wire [8:0] rx_nxt = {s_io, shift_ff[8:1]};
  wire [8:0] rx_word = proto_ff[`B_NINE] ? rx_nxt :
    {1'b0, rx_nxt[8:1]};
  wire [3:0] last_bit = proto_ff[`B_NINE] ? 4'h8 : 4'h7;

  // register strobes
  wire wr_hit = wr_stb;
  wire w_int = wr_hit && addr == `A_INT;
  wire tx_push = wr_hit && addr == `A_TXDATA && tx_cnt_ff != 3'h4;
  wire tx_rd = rd_stb && addr == `A_TXDATA;
  wire tx_reset = tx_rd & tx_rd_prev_ff;
  wire tx_pop = count_fall & txdir_ff & (tx_cnt_ff != 3'h0) &
    (bitp_ff == 4'h7) & ~tx_reset;
  wire rx_push = rise_ev & counting & ~txdir_ff & (bitp_ff == last_bit) &
    (rx_cnt_ff != 3'h4);
  wire rx_pop = rd_stb && addr == `A_RXDATA && rx_cnt_ff != 3'h0;
  wire w_supply = wr_hit && addr == `A_SUPPLY;
  wire fault_ev = s_fault & fault_en_ff;
  wire dir_change = wr_hit && addr == `A_TXCTL &&
    wr_data[`B_TXDIR] != txdir_ff;

  always @(posedge core_clk) begin
    if (srst) begin
      proto_ff <= 8'h00;
      clk_stop_ff <= 1'b1;
      clk_lvl_ff <= 1'b0;
      etu_div_ff <= `ETU_DIV_RST;
      rlen_load_ff <= 8'h00;
      rlen_cnt_ff <= 8'h00;
      rlen_fresh_ff <= 1'b0;
      len_flag_ff <= 1'b0;
      receive_data_available_ff <= 1'b0;
      ie_ff <= 8'h00;
      cctl_data_ff <= 1'b0;
      cctl_dir_ff <= 1'b0;
      io_samp_ff <= 1'b0;
      dline_ff <= 1'b0;
      txdir_ff <= 1'b0;
      ninth_ff <= 1'b0;
      tx_wp_ff <= 2'h0;
      tx_rp_ff <= 2'h0;
      tx_cnt_ff <= 3'h0;
      tx_rd_prev_ff <= 1'b0;
      rx_wp_ff <= 2'h0;
      rx_rp_ff <= 2'h0;
      rx_cnt_ff <= 3'h0;
      shift_ff <= 9'h000;
      bitp_ff <= 4'h0;
    end else begin
      if (wr_hit) begin
        case (addr)
          `A_PROTO: proto_ff <= wr_data & 8'hE0;
          `A_CLKREG: begin
            clk_stop_ff <= wr_data[`B_STOP];
            clk_lvl_ff <= wr_data[`B_LVL];
          end
          `A_ETU: etu_div_ff <= wr_data;
          `A_IE: ie_ff <= wr_data;
          `A_CCTL: begin
            cctl_data_ff <= wr_data[`B_IODATA];
            cctl_dir_ff <= wr_data[`B_IODIR];
          end
          `A_TXCTL: begin
            dline_ff <= wr_data[`B_DLINE];
            txdir_ff <= wr_data[`B_TXDIR];
          end
          default: ;
        endcase
      end
      // a reload restarts the count; only then can counting resume
      if (wr_hit && addr == `A_RLEN) begin
        rlen_load_ff <= wr_data;
        rlen_cnt_ff <= 8'h00;
        rlen_fresh_ff <= 1'b1;
      end else if (count_fall) begin
        rlen_cnt_ff <= rlen_cnt_ff + 8'h01;
        rlen_fresh_ff <= 1'b0;
      end
      // set wins over a write-one clear
      if (count_fall && rlen_cnt_ff + 8'h01 == rlen_load_ff)
        len_flag_ff <= 1'b1;
      else if (w_int && wr_data[`B_LEN])
        len_flag_ff <= 1'b0;
      if (rx_push)
        receive_data_available_ff <= 1'b1;
      else if (w_int && wr_data[`B_RECEIVE_DATA_AVAILABLE])
        receive_data_available_ff <= 1'b0;
      if (sync_run && rise_ev)
        io_samp_ff <= s_io;
      // serializer / deserializer, LSB first
      if (dir_change)
        bitp_ff <= 4'h0;
      else if (txdir_ff && count_fall && tx_cnt_ff != 3'h0)
        bitp_ff <= (bitp_ff == 4'h7) ? 4'h0 : bitp_ff + 4'h1;
      else if (!txdir_ff && rise_ev && counting) begin
        shift_ff <= rx_nxt;
        bitp_ff <= (bitp_ff == last_bit) ? 4'h0 : bitp_ff + 4'h1;
      end
      if (tx_push) begin
        tx_mem[tx_wp_ff] <= wr_data;
      end
      if (tx_rd | (rd_stb | wr_stb))
        tx_rd_prev_ff <= tx_rd & ~tx_reset;
      if (tx_reset) begin
        tx_wp_ff <= tx_rp_ff;
        tx_cnt_ff <= 3'h0;
      end else begin
        if (tx_push)
          tx_wp_ff <= tx_wp_ff + 2'h1;
        if (tx_pop)
          tx_rp_ff <= tx_rp_ff + 2'h1;
        tx_cnt_ff <= tx_cnt_ff + {2'b00, tx_push} - {2'b00, tx_pop};
      end
      if (rx_push) begin
        rx_mem[rx_wp_ff] <= rx_word;
        rx_wp_ff <= rx_wp_ff + 2'h1;
      end
      if (rx_pop) begin
        rx_rp_ff <= rx_rp_ff + 2'h1;
        ninth_ff <= rx_mem[rx_rp_ff][8];
      end
      rx_cnt_ff <= rx_cnt_ff + {2'b00, rx_push} - {2'b00, rx_pop};
    end
  end

  // supply register and activation sequencer
  always @(posedge core_clk) begin
    if (srst) begin
      vsel_ff <= 2'b00;
      vcode_ff <= 2'b00;
      fault_en_ff <= 1'b0;
      ready_start_ff <= 1'b0;
      pwroff_ff <= 1'b0;
      lock_ff <= 1'b0;
      good_d_ff <= 1'b0;
      state_ff <= `ST_IDLE;
      tmr_ff <= 16'h0000;
    end else begin
      good_d_ff <= s_good;
      if (w_supply) begin
        // both select bits land together in one write
        vsel_ff <= wr_data[`B_VSEL1:`B_VSEL0];
        fault_en_ff <= wr_data[`B_FAULT];
        ready_start_ff <= wr_data[`B_READY_START];
        pwroff_ff <= wr_data[`B_PWROFF];
        if (wr_data[`B_VSEL1:`B_VSEL0] == 2'b00)
          lock_ff <= 1'b0;
      end
      if (fault_ev) begin
        fault_en_ff <= 1'b0;
        vsel_ff <= 2'b00;
      end
      case (state_ff)
        `ST_IDLE: begin
          tmr_ff <= 16'h0000;
          if (vsel_ff != 2'b00 && !lock_ff && !fault_ev) begin
            vcode_ff <= vsel_ff;
            state_ff <= `ST_WAIT;
          end
        end
        `ST_WAIT: begin
          if (tmr_ff != 16'hFFFF)
            tmr_ff <= tmr_ff + 16'h0001;
          if (vsel_ff == 2'b00 || fault_ev)
            state_ff <= `ST_D_RST;
          else if (ready_start_ff ? s_good : tmr_ff >= `SUPPLY_CYC - 1)
            state_ff <= `ST_ACTIVE;
        end
        `ST_ACTIVE: begin
          if (s_event || (good_d_ff && !s_good)) begin
            lock_ff <= 1'b1;
            state_ff <= `ST_D_RST;
          end else if (vsel_ff == 2'b00 || fault_ev)
            state_ff <= `ST_D_RST;
        end
        `ST_D_RST: state_ff <= `ST_D_CLK;
        `ST_D_CLK: state_ff <= `ST_D_IO;
        `ST_D_IO: state_ff <= `ST_D_VCC;
        `ST_D_VCC: state_ff <= `ST_IDLE;
        default: state_ff <= `ST_IDLE;
      endcase
    end
  end

  // pin and read-back registers
  reg [7:0] rd_mux;
  always @* begin
    case (addr)
      `A_SUPPLY: rd_mux = {vsel_ff, fault_en_ff, ready_start_ff, s_good,
        2'b00, pwroff_ff};
      `A_PROTO: rd_mux = proto_ff;
      `A_CLKREG: rd_mux = {6'h00, clk_lvl_ff, clk_stop_ff};
      `A_ETU: rd_mux = etu_div_ff;
      `A_RLEN: rd_mux = rlen_cnt_ff;
      `A_INT: rd_mux = {len_flag_ff, 6'h00, receive_data_available_ff};
      `A_IE: rd_mux = ie_ff;
      `A_CCTL: rd_mux = {2'b00, io_samp_ff, 3'b000, cctl_dir_ff,
        cctl_data_ff};
      `A_TXCTL: rd_mux = {dline_ff, txdir_ff, 6'h00};
      `A_RXCTL: rd_mux = {ninth_ff, 6'h00, rx_cnt_ff == 3'h0};
      `A_TXDATA: rd_mux = tx_mem[tx_rp_ff];
      `A_RXDATA: rd_mux = rx_mem[rx_rp_ff][7:0];
      default: rd_mux = 8'h00;
    endcase
  end
  wire io_live = state_ff == `ST_ACTIVE || state_ff == `ST_D_RST ||
    state_ff == `ST_D_CLK;
  always @(posedge core_clk) begin
    if (srst) begin
      rd_data_ff <= 8'h00;
      card_io_out_ff <= 1'b0;
      card_io_oe_n_ff <= 1'b1;
      card_rst_n_ff <= 1'b0;
      vcc_sel_out_ff <= 2'b00;
      chip_off_ff <= 1'b0;
      irq_ff <= 1'b0;
    end else begin
      rd_data_ff <= rd_stb ? rd_mux : 8'h00;
      if (!io_live) begin
        card_io_out_ff <= 1'b0;
        card_io_oe_n_ff <= 1'b1;
      end else if (direct) begin
        card_io_out_ff <= cctl_data_ff;
        card_io_oe_n_ff <= ~cctl_dir_ff;
      end else begin
        card_io_out_ff <= tx_bit;
        card_io_oe_n_ff <= ~(txdir_ff && tx_cnt_ff != 3'h0);
      end
      card_rst_n_ff <= state_ff == `ST_ACTIVE;
      vcc_sel_out_ff <= (state_ff == `ST_IDLE) ? 2'b00 : vcode_ff;
      // power off waits for bus power to go away
      chip_off_ff <= pwroff_ff & ~s_bus;
      irq_ff <= (len_flag_ff & ie_ff[`B_LEN]) |
        (receive_data_available_ff & ie_ff[`B_RECEIVE_DATA_AVAILABLE]);
    end
  end
endmodule // sc_sync_supply

// ---- tb/sc_sync_supply_sva.sv ----
// port-level assertions for the card supply sequencer and card clock
module sc_sync_supply_sva (
  // clock and reset
  input wire core_clk,
  input wire srst,
  // observed ports
  input wire wr_stb,
  input wire card_clk_ff,
  input wire card_io_oe_n_ff,
  input wire card_rst_n_ff,
  input wire bus_power_in,
  input wire [1:0] vcc_sel_out_ff,
  input wire chip_off_ff
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (srst);

  a_vcc_on_write: assert property (
    $rose(|vcc_sel_out_ff) |->
      $past(wr_stb, 1) || $past(wr_stb, 2) || $past(wr_stb, 3))
    else $error("card supply rose without a register write");
  a_rst_needs_vcc: assert property (
    card_rst_n_ff |-> vcc_sel_out_ff != 2'b00)
    else $error("card reset released with supply off");
  a_deact_order: assert property (
    $fell(|vcc_sel_out_ff) |-> $past(!card_rst_n_ff, 2))
    else $error("supply dropped before card reset went low");
  a_line_before_vcc: assert property (
    $fell(|vcc_sel_out_ff) |-> card_io_oe_n_ff && $past(card_io_oe_n_ff))
    else $error("card line still driven when supply dropped");
  a_clk_needs_vcc: assert property (
    vcc_sel_out_ff == 2'b00 |-> !card_clk_ff)
    else $error("card clock high with supply off");
  a_clk_high_half: assert property (
    $rose(card_clk_ff) |-> card_clk_ff [*4])
    else $error("card clock high phase cut short");
  a_clk_low_half: assert property (
    $fell(card_clk_ff) |-> !card_clk_ff [*4])
    else $error("card clock low phase cut short");
  a_off_no_bus: assert property (
    $rose(chip_off_ff) |-> !bus_power_in && !$past(bus_power_in, 3))
    else $error("power off taken while bus power present");
endmodule // sc_sync_supply_sva

bind sc_sync_supply sc_sync_supply_sva chk (.*);

// ---- tb/card_model.sv ----
// behavioural synchronous card: shifts a word out LSB first on clock falls
module card_model (
  // card pins
  input wire card_clk_ff,
  input wire card_io_oe_n_ff,
  input wire card_io_out_ff,
  output wire card_io_in,
  // bench control
  input wire [15:0] tx_word,
  input wire restart
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [3:0] idx = 4'h0;

  // next bit set up on the fall so it is steady at the sampling rise
  always @(negedge card_clk_ff or posedge restart) begin
    if (restart)
      idx <= 4'h0;
    else if (idx != 4'hF)
      idx <= idx + 4'h1;
  end
  // card yields the line whenever the device drives it
  assign card_io_in = !card_io_oe_n_ff ? card_io_out_ff : tx_word[idx];
endmodule // card_model

// ---- tb/tb_top.sv ----
// register-level bench for the synchronous card engine and supply control
`include "sc_defs.vh"
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin \
  failures++; $display("Error %0t: got %h exp %h", $time, g, e); end end
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic core_clk = 0, srst = 1, wr_stb = 0, rd_stb = 0, restart = 0;
  logic [15:0] addr = 16'h0000, tx_word = 16'h0000;
  logic [7:0] wr_data = 8'h00, rd_data_ff;
  logic card_event_in = 0, supply_good_in = 0, supply_fault_in = 0;
  logic bus_power_in = 1, card_clk_ff, card_io_in, card_io_out_ff;
  logic card_io_oe_n_ff, card_rst_n_ff, chip_off_ff, irq_ff;
  logic [1:0] vcc_sel_out_ff;
  logic [7:0] seen = 8'h00;
  int failures = 0, samples_checked = 0;

  sc_sync_supply dut (.*);
  card_model card (.*);

  always #5 core_clk = ~core_clk;

  // the card's view of the driven line at each sampling rise, LSB first
  always @(posedge card_clk_ff)
    if (!card_io_oe_n_ff)
      seen <= {card_io_out_ff, seen[7:1]};

  task cyc(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task wr(input [15:0] a, input [7:0] d);
    @(posedge core_clk);
    addr <= a;
    wr_data <= d;
    wr_stb <= 1;
    @(posedge core_clk);
    wr_stb <= 0;
  endtask
  // data stands only in the cycle after the read edge
  task rd(input [15:0] a, input [7:0] e);
    @(posedge core_clk);
    addr <= a;
    rd_stb <= 1;
    @(posedge core_clk);
    rd_stb <= 0;
    #1;
    `CHK(rd_data_ff, e)
  endtask
  task rx_word(input [15:0] w, input [7:0] len);
    tx_word <= w;
    restart <= 1;
    @(posedge core_clk);
    restart <= 0;
    wr(`A_RLEN, len);
    wr(`A_CLKREG, 8'h00);
    cyc(110);
    wr(`A_CLKREG, 8'h01);
    cyc(10);
  endtask
  task test_done();
    if (failures == 0 && samples_checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  initial begin
    #300_000;
    failures++;
    test_done();
  end

  initial begin
    cyc(6);
    srst <= 0;
    rd(`A_SUPPLY, 8'h00);
    rd(`A_ETU, `ETU_DIV_RST);
    rd(16'hFE00, 8'h00);
    wr(`A_SUPPLY, 8'h01);
    cyc(10);
    `CHK(chip_off_ff, 1'b0)
    bus_power_in <= 0;
    cyc(10);
    `CHK(chip_off_ff, 1'b1)
    wr(`A_SUPPLY, 8'h00);
    bus_power_in <= 1;
    wr(`A_SUPPLY, 8'h50);
    cyc(50);
    `CHK(card_rst_n_ff, 1'b0)
    supply_good_in <= 1;
    cyc(10);
    `CHK(card_rst_n_ff, 1'b1)
    `CHK(vcc_sel_out_ff, 2'b01)
    wr(`A_TXDATA, 8'h11);
    wr(`A_TXDATA, 8'h22);
    rd(`A_TXDATA, 8'h11);
    rd(`A_TXDATA, 8'h11);
    wr(`A_TXDATA, 8'h33);
    rd(`A_TXDATA, 8'h33);
    wr(`A_PROTO, 8'h80);
    wr(`A_IE, 8'h00);
    rx_word(16'hFFA5, 8'h08);
    rd(`A_RLEN, 8'h08);
    rd(`A_INT, 8'h81);
    `CHK(irq_ff, 1'b0)
    wr(`A_IE, 8'h80);
    cyc(3);
    `CHK(irq_ff, 1'b1)
    rd(`A_CCTL, 8'h20);
    rd(`A_RXDATA, 8'hA5);
    rd(`A_RXCTL, 8'h01);
    wr(`A_INT, 8'hFF);
    cyc(3);
    `CHK(irq_ff, 1'b0)
    wr(`A_PROTO, 8'hC0);
    rx_word(16'h013C, 8'h09);
    rd(`A_RXDATA, 8'h3C);
    rd(`A_RXCTL, 8'h81);
    rd(`A_CCTL, 8'h00);
    // three received bits leave the bit pointer part way into a word
    wr(`A_PROTO, 8'h80);
    wr(`A_RLEN, 8'h03);
    wr(`A_CLKREG, 8'h00);
    cyc(40);
    wr(`A_CLKREG, 8'h01);
    cyc(10);
    rd(`A_TXDATA, 8'h33);
    rd(`A_TXDATA, 8'h33);
    wr(`A_TXCTL, 8'h40);
    wr(`A_TXDATA, 8'h96);
    wr(`A_RLEN, 8'h08);
    wr(`A_CLKREG, 8'h00);
    cyc(80);
    wr(`A_CLKREG, 8'h01);
    cyc(10);
    `CHK(seen, 8'h96)
    // stop high, then restart with a fresh load
    wr(`A_CLKREG, 8'h02);
    cyc(4);
    wr(`A_CLKREG, 8'h03);
    cyc(20);
    `CHK(card_clk_ff, 1'b1)
    wr(`A_RLEN, 8'h05);
    wr(`A_CLKREG, 8'h00);
    cyc(10);
    wr(`A_CLKREG, 8'h03);
    cyc(10);
    rd(`A_RLEN, 8'h01);
    `CHK(card_clk_ff, 1'b1)
    wr(`A_RLEN, 8'h00);
    wr(`A_TXCTL, 8'h80);
    wr(`A_CCTL, 8'h03);
    cyc(3);
    `CHK({card_io_oe_n_ff, card_io_out_ff}, 2'b01)
    wr(`A_CCTL, 8'h02);
    cyc(3);
    `CHK({card_io_oe_n_ff, card_io_out_ff}, 2'b00)
    wr(`A_CCTL, 8'h00);
    cyc(3);
    `CHK(card_io_oe_n_ff, 1'b1)
    wr(`A_TXCTL, 8'h00);
    wr(`A_SUPPLY, 8'h00);
    cyc(10);
    `CHK(vcc_sel_out_ff, 2'b00)
    wr(`A_SUPPLY, 8'h40);
    cyc(900);
    `CHK(card_rst_n_ff, 1'b0)
    cyc(150);
    `CHK(card_rst_n_ff, 1'b1)
    wr(`A_SUPPLY, 8'h00);
    cyc(10);
    wr(`A_SUPPLY, 8'h70);
    cyc(10);
    supply_fault_in <= 1;
    cyc(4);
    rd(`A_SUPPLY, 8'h18);
    cyc(10);
    `CHK(vcc_sel_out_ff, 2'b00)
    supply_fault_in <= 0;
    wr(`A_SUPPLY, 8'h50);
    cyc(10);
    card_event_in <= 1;
    cyc(10);
    `CHK(vcc_sel_out_ff, 2'b00)
    card_event_in <= 0;
    wr(`A_SUPPLY, 8'h50);
    cyc(10);
    `CHK(vcc_sel_out_ff, 2'b00)
    wr(`A_SUPPLY, 8'h10);
    wr(`A_SUPPLY, 8'h50);
    cyc(10);
    `CHK(vcc_sel_out_ff, 2'b01)
    test_done();
  end
endmodule // tb_top
